// ==== core/local_bus_cycle_input_sampling.v ====
`timescale 1ns/1ps
`include "lbus_consts.vh"

// Functional notes
// - bus clock period is twice input clock
// - half-cycle equals one input clock period
// - every access state starts on falling edge
// - host request low at release selects self-bootstrap
// - timing select low at release selects big-endian
// - configuration sampled once per row in state two
// - configuration captured on bus clock rising edge
// - ready, retry, fault sampled entering row three
// - completion inputs captured on bus clock falling edge
// - ready also sampled at row six, columns
// - retry sampled every falling edge after row three
module local_bus_cycle_input_sampling (
    // system clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // avalon-mm register slave
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // clock and reset pins
    input wire input_clock_i,
    input wire reset_n_i,
    output reg bus_output_clock_o,
    // reset straps
    input wire host_request_strap_n_i,
    input wire user_timing_select_i,
    // cycle configuration inputs
    input wire [2:0] addr_shift_select_i,
    input wire [1:0] bus_width_select_i,
    input wire [2:0] cycle_kind_select_i,
    input wire [3:0] page_extent_select_i,
    // cycle completion inputs
    input wire ready_i,
    input wire retry_i,
    input wire fault_i,
    // captured modes and access state
    output reg self_boot_o,
    output reg big_endian_o,
    output reg access_busy_o
);

    // access sequencer states
    localparam ST_IDLE = 4'h0;
    localparam ST_ROW1 = 4'h1;
    localparam ST_ROW2 = 4'h2;
    localparam ST_ROW3 = 4'h3;
    localparam ST_ROW4 = 4'h4;
    localparam ST_ROW5 = 4'h5;
    localparam ST_ROW6 = 4'h6;
    localparam ST_COL = 4'h7;

    // synchronised pins
    wire [18:0] pin_sync;
    wire in_clk_s;
    wire rst_n_s;
    wire boot_req_n_s;
    wire [`LB_CFG_W-1:0] cfg_s;
    wire ready_s;
    wire retry_s;
    wire fault_s;

    // every outside pin passes two flip-flops before use
    sync2 #(
        .W(19)
    ) u_pin_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .d_i({input_clock_i, reset_n_i, host_request_strap_n_i, user_timing_select_i,
              page_extent_select_i, cycle_kind_select_i, bus_width_select_i,
              addr_shift_select_i, ready_i, retry_i, fault_i}),
        .q_o(pin_sync)
    );

    assign in_clk_s = pin_sync[18];
    assign rst_n_s = pin_sync[17];
    assign boot_req_n_s = pin_sync[16];
    assign cfg_s = pin_sync[15:3];
    assign ready_s = pin_sync[2];
    assign retry_s = pin_sync[1];
    assign fault_s = pin_sync[0];

    // edge finding on the sampled input clock and reset pin
    reg in_clk_d_r;
    reg rst_n_d_r;
    wire half_tick;
    wire rst_release;
    wire dev_rst;

    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            in_clk_d_r <= 1'b0;
            rst_n_d_r <= 1'b0;
        end
        else
        begin
            in_clk_d_r <= in_clk_s;
            rst_n_d_r <= rst_n_s;
        end
    end

    // one half-cycle per input clock rise
    assign half_tick = in_clk_s & ~in_clk_d_r;
    assign rst_release = rst_n_s & ~rst_n_d_r;
    assign dev_rst = sys_rst_i | ~rst_n_s;

    // bus clock edges as seen before the toggle
    wire clko_fall = half_tick & bus_output_clock_o;
    wire clko_rise = half_tick & ~bus_output_clock_o;

    // toggle register, held low in reset
    // toggling on each half-cycle doubles the period
    always @(posedge clock_i)
    begin
        if (dev_rst)
            bus_output_clock_o <= 1'b0;
        else if (half_tick)
            bus_output_clock_o <= ~bus_output_clock_o;
    end

    // reset pulse width check; a short pulse is flagged, not rejected
    reg [3:0] rst_half_r;
    reg short_rst_r;
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            rst_half_r <= 4'h0;
            short_rst_r <= 1'b0;
        end
        else if (rst_n_s)
        begin
            rst_half_r <= 4'h0;
            if (rst_release)
                short_rst_r <= (rst_half_r < `LB_RESET_MIN_HALF);
        end
        else if (half_tick && rst_half_r != 4'hf)
            rst_half_r <= rst_half_r + 4'h1;
    end

    // straps are caught by a clocked process at the release, never by reset
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            self_boot_o <= 1'b0;
            big_endian_o <= 1'b0;
        end
        else if (rst_release)
        begin
            self_boot_o <= ~boot_req_n_s;
            big_endian_o <= ~cfg_s[12];
        end
    end

    // control fields written by software, sequencer state and column counters
    reg [1:0] cpc_r;
    reg [3:0] ncol_r;
    reg start_pend_r;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [3:0] col_left_r;
    reg [1:0] col_cyc_r;

    // sampled completion flags
    reg rdy3_r;
    reg rdy6_r;
    reg retry_r;
    reg fault_r;

    wire bus_acc = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    wire wr_take = avs_write_i & ~avs_waitrequest_o;
    wire ctrl_wr = wr_take & (avs_address_i == `LB_OFS_CTRL);
    wire start_req = ctrl_wr & avs_byteenable_i[0] & avs_writedata_i[`LB_CTRL_START_BIT];
    wire take_start = clko_fall & (state_r == ST_IDLE) & start_pend_r;
    wire slow_col = (cpc_r >= 2'h2);
    wire col_end = (col_cyc_r + 2'h1 >= cpc_r);

    wire [`LB_CFG_W-1:0] cfg_q;

    // configuration taken on the rising bus clock edge
    // only while the row is in state two
    capture_reg #(
        .W(`LB_CFG_W)
    ) u_cfg_cap (
        .clock_i(clock_i),
        .sys_rst_i(dev_rst),
        .load_i(clko_rise & (state_r == ST_ROW2)),
        .d_i(cfg_s),
        .q_o(cfg_q)
    );

    // control register and start request; the set wins over the take
    always @(posedge clock_i)
    begin
        if (dev_rst)
        begin
            cpc_r <= `LB_CPC_RST;
            ncol_r <= `LB_NCOL_RST;
            start_pend_r <= 1'b0;
        end
        else
        begin
            if (ctrl_wr && avs_byteenable_i[0])
                cpc_r <= avs_writedata_i[`LB_CTRL_CPC_MSB:`LB_CTRL_CPC_LSB];
            if (ctrl_wr && avs_byteenable_i[1])
                ncol_r <= avs_writedata_i[`LB_CTRL_NCOL_MSB:`LB_CTRL_NCOL_LSB];
            start_pend_r <= (start_pend_r & ~take_start) | start_req;
        end
    end

    // next state, advanced only on falling bus clock edges
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (start_pend_r) state_nxt = ST_ROW1;
            ST_ROW1: state_nxt = ST_ROW2;
            ST_ROW2: state_nxt = ST_ROW3;
            ST_ROW3: state_nxt = ST_ROW4;
            ST_ROW4: state_nxt = ST_ROW5;
            ST_ROW5: state_nxt = ST_ROW6;
            ST_ROW6: state_nxt = (ncol_r == 4'h0) ? ST_IDLE : ST_COL;
            ST_COL:
            begin
                if (col_end && (!slow_col || ready_s) && col_left_r == 4'h1)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        // a retry after row three abandons the access
        if (state_r >= ST_ROW3 && retry_s)
            state_nxt = ST_IDLE;
        // a retry at entry to row three abandons it too
        if (state_r == ST_ROW2 && retry_s)
            state_nxt = ST_IDLE;
    end

    // states change only on the falling bus clock edge
    always @(posedge clock_i)
    begin
        if (dev_rst)
        begin
            state_r <= ST_IDLE;
            col_left_r <= 4'h0;
            col_cyc_r <= 2'h0;
        end
        else if (clko_fall)
        begin
            state_r <= state_nxt;
            if (state_r == ST_ROW6)
            begin
                col_left_r <= ncol_r;
                col_cyc_r <= 2'h0;
            end
            else if (state_r == ST_COL)
            begin
                // slow columns wait while ready is low
                if (!col_end)
                    col_cyc_r <= col_cyc_r + 2'h1;
                else if (!slow_col || ready_s)
                begin
                    col_cyc_r <= 2'h0;
                    col_left_r <= col_left_r - 4'h1;
                end
            end
        end
    end

    // completion flags; a new access clears them, the clear wins over hardware sets
    always @(posedge clock_i)
    begin
        if (dev_rst)
        begin
            rdy3_r <= 1'b0;
            rdy6_r <= 1'b0;
            retry_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else if (take_start)
        begin
            rdy3_r <= 1'b0;
            rdy6_r <= 1'b0;
            retry_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else if (clko_fall)
        begin
            // completion inputs taken on the falling edge
            if (state_r == ST_ROW2)
            begin
                rdy3_r <= ready_s;
                fault_r <= fault_s;
            end
            if (state_r == ST_ROW5)
                rdy6_r <= ready_s;
            // retry watched from row three onward
            if (state_r >= ST_ROW2 && retry_s)
                retry_r <= 1'b1;
        end
    end

    // busy output follows the sequencer; it moves only with the state,
    // so it never rises ahead of the falling bus clock edge
    // busy changes with the state on the fall
    always @(posedge clock_i)
    begin
        if (dev_rst)
            access_busy_o <= 1'b0;
        else if (clko_fall)
            access_busy_o <= (state_nxt != ST_IDLE);
        else
            access_busy_o <= (state_r != ST_IDLE);
    end

    // avalon answer one cycle after the request, then waitrequest rises again
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest_o <= ~bus_acc;
            if (bus_acc && avs_read_i)
            begin
                case (avs_address_i)
                    `LB_OFS_CTRL:
                        avs_readdata_o <= {20'h0_0000, ncol_r, 2'h0, cpc_r, 3'h0,
                                           start_pend_r};
                    `LB_OFS_STATUS:
                        avs_readdata_o <= {20'h0_0000, state_r, short_rst_r, big_endian_o,
                                           self_boot_o, rdy6_r, fault_r, retry_r, rdy3_r,
                                           access_busy_o};
                    `LB_OFS_CFG:
                        avs_readdata_o <= {19'h0_0000, cfg_q};
                    default: avs_readdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // local_bus_cycle_input_sampling

// ==== inc/lbus_consts.vh ====
`ifndef LBUS_CONSTS_VH
`define LBUS_CONSTS_VH

// register byte offsets (word aligned)
`define LB_OFS_CTRL 4'h0
`define LB_OFS_STATUS 4'h4
`define LB_OFS_CFG 4'h8

// control register fields
`define LB_CTRL_START_BIT 0
`define LB_CTRL_CPC_LSB 4
`define LB_CTRL_CPC_MSB 5
`define LB_CTRL_NCOL_LSB 8
`define LB_CTRL_NCOL_MSB 11

// control reset values
`define LB_CPC_RST 2'h1
`define LB_NCOL_RST 4'h0

// status register fields
`define LB_ST_BUSY_BIT 0
`define LB_ST_RDY3_BIT 1
`define LB_ST_RETRY_BIT 2
`define LB_ST_FAULT_BIT 3
`define LB_ST_RDY6_BIT 4
`define LB_ST_SELFBOOT_BIT 5
`define LB_ST_BIGEND_BIT 6
`define LB_ST_SHORTRST_BIT 7
`define LB_ST_STATE_LSB 8
`define LB_ST_STATE_MSB 11

// config capture width
`define LB_CFG_W 13

// timing counts in half-cycles (one input clock period each)
`define LB_RESET_MIN_HALF 4'h6
`define LB_STRAP_SETUP_HALF 4'h4

`endif

// ==== core/sync2.v ====
`timescale 1ns/1ps

// two-stage synchroniser for pins arriving from outside the clock domain
module sync2 #(
    parameter W = 1
) (
    // clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // data
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);

    reg [W-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            meta_r <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule // sync2

// ==== core/capture_reg.v ====
`timescale 1ns/1ps

// load-enabled capture register for sampled bus inputs
module capture_reg #(
    parameter W = 1
) (
    // clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // capture control
    input wire load_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);

    // hold value between sampling points
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
            q_o <= {W{1'b0}};
        else if (load_i)
            q_o <= d_i;
    end

endmodule // capture_reg

// ==== tb/lbus_sva.sv ====
`timescale 1ns/1ps
// pin-level checks on bus clock, straps and access timing
module lbus_sva (
    // clock and resets
    input wire clock_i,
    input wire sys_rst_i,
    input wire reset_n_i,
    // strap pins
    input wire host_request_strap_n_i,
    input wire user_timing_select_i,
    // watched outputs
    input wire bus_output_clock_o,
    input wire self_boot_o,
    input wire big_endian_o,
    input wire access_busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i || !reset_n_i);
    AST_RST_LOW: assert property (disable iff (1'b0)
        sys_rst_i || !(reset_n_i || $past(reset_n_i, 4)) |=> !bus_output_clock_o)
        else $error("bus clock moved in reset");
    // low phase length; the guard skips the first edges after a pin reset
    AST_RISE_GAP: assert property (
        $rose(bus_output_clock_o) && $past(reset_n_i, 70)
        |-> !$past(bus_output_clock_o, 31) && $past(bus_output_clock_o, 33))
        else $error("bus clock low phase wrong");
    AST_FALL_GAP: assert property (
        $fell(bus_output_clock_o) && $past(reset_n_i, 70)
        |-> $past(bus_output_clock_o, 31) && !$past(bus_output_clock_o, 33))
        else $error("bus clock high phase wrong");
    AST_STEADY: assert property (
        $changed(bus_output_clock_o) |=> $stable(bus_output_clock_o) [*8])
        else $error("bus clock glitch");
    AST_BUSY_START: assert property (
        $rose(access_busy_o) |-> $fell(bus_output_clock_o))
        else $error("access began off a falling edge");
    AST_BUSY_END: assert property (
        $fell(access_busy_o) |-> $fell(bus_output_clock_o))
        else $error("access ended off a falling edge");
    AST_BOOT_CAPT: assert property (
        $changed(self_boot_o) |-> !$past(reset_n_i, 6)
        && self_boot_o == !$past(host_request_strap_n_i, 3))
        else $error("boot mode changed wrongly");
    AST_ENDIAN_CAPT: assert property (
        $changed(big_endian_o) |-> !$past(reset_n_i, 6)
        && big_endian_o == !$past(user_timing_select_i, 3))
        else $error("byte order changed wrongly");
endmodule // lbus_sva

bind local_bus_cycle_input_sampling lbus_sva u_sva (
    .clock_i, .sys_rst_i, .reset_n_i, .host_request_strap_n_i, .user_timing_select_i,
    .bus_output_clock_o, .self_boot_o, .big_endian_o, .access_busy_o
);

// ==== tb/mem_side_model.sv ====
`timescale 1ns/1ps
// far side: input clock, reset pin, straps, static decode and completions
module mem_side_model (
    // clocks
    input wire clock_i,
    input wire bus_output_clock_o,
    // values asked for by the bench
    input wire [12:0] cfg_req_i,
    input wire [2:0] cmp_req_i,
    // pins towards the block
    output reg input_clock_i,
    output reg reset_n_i,
    output wire host_request_strap_n_i,
    output wire user_timing_select_i,
    output wire [2:0] addr_shift_select_i,
    output wire [1:0] bus_width_select_i,
    output wire [2:0] cycle_kind_select_i,
    output wire [3:0] page_extent_select_i,
    output reg ready_i,
    output reg retry_i,
    output reg fault_i
);
    reg prev_r, strap_on, boot_n, endian_n;
    reg [12:0] cfg_r;
    // straps share pins; request line idles high
    assign host_request_strap_n_i = strap_on ? boot_n : 1'b1;
    assign user_timing_select_i = strap_on ? endian_n : cfg_r[12];
    assign {page_extent_select_i, cycle_kind_select_i, bus_width_select_i,
        addr_shift_select_i} = cfg_r[11:0];
    // free input clock, phase unrelated to the bench clock
    initial
    begin
        {reset_n_i, strap_on, prev_r, cfg_r} = 16'h0000;
        {ready_i, retry_i, fault_i, boot_n, endian_n} = 5'h13;
        input_clock_i = 1'b0;
        #13;
        forever #80 input_clock_i = ~input_clock_i;
    end
    // decode moves after a fall; completions move after a rise
    always @(posedge clock_i)
    begin
        prev_r <= bus_output_clock_o;
        if (prev_r && !bus_output_clock_o)
            cfg_r <= cfg_req_i;
        if (!prev_r && bus_output_clock_o)
            {ready_i, retry_i, fault_i} <= cmp_req_i;
    end
    // seven half-cycles low, straps set throughout and held after
    task pin_reset(input boot, input endian);
    begin
        @(posedge clock_i);
        strap_on <= 1'b1;
        boot_n <= boot;
        endian_n <= endian;
        reset_n_i <= 1'b0;
        repeat (7) @(posedge input_clock_i);
        @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge input_clock_i);
        @(posedge clock_i);
        strap_on <= 1'b0;
    end
    endtask
endmodule // mem_side_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
// random and corner accesses against the local bus sampling block
module testbench;
    reg clock_i, sys_rst_i, avs_read_i, avs_write_i;
    reg [3:0] avs_address_i;
    reg [3:0] avs_byteenable_i = 4'hf;
    reg [31:0] avs_writedata_i, q, ctl;
    reg [12:0] cfg_req;
    reg [2:0] cmp_req;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, input_clock_i, reset_n_i, bus_output_clock_o;
    wire host_request_strap_n_i, user_timing_select_i, ready_i, retry_i, fault_i;
    wire [2:0] addr_shift_select_i, cycle_kind_select_i;
    wire [1:0] bus_width_select_i;
    wire [3:0] page_extent_select_i;
    wire self_boot_o, big_endian_o, access_busy_o;
    integer fails, checks_done, cyc, i, n;

    local_bus_cycle_input_sampling u_dut (
        .clock_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .input_clock_i, .reset_n_i, .bus_output_clock_o, .host_request_strap_n_i,
        .user_timing_select_i, .addr_shift_select_i, .bus_width_select_i,
        .cycle_kind_select_i, .page_extent_select_i, .ready_i, .retry_i, .fault_i,
        .self_boot_o, .big_endian_o, .access_busy_o
    );
    mem_side_model u_mem (
        .clock_i, .bus_output_clock_o, .cfg_req_i(cfg_req), .cmp_req_i(cmp_req),
        .input_clock_i, .reset_n_i, .host_request_strap_n_i, .user_timing_select_i,
        .addr_shift_select_i, .bus_width_select_i, .cycle_kind_select_i,
        .page_extent_select_i, .ready_i, .retry_i, .fault_i
    );

    // 200 MHz clock
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // hang guard, well above the planned run
    always @(posedge clock_i)
    begin
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            fails = fails + 1;
            print_verdict;
        end
    end

    task chk(input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // one transfer, held until waitrequest is seen low
    task av(input w, input [3:0] a, input [31:0] d);
    begin
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clock_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    end
    endtask
    task wait_busy(input lvl);
    begin
        for (n = 0; access_busy_o !== lvl && n < 3000; n = n + 1)
            @(posedge clock_i);
        chk(n < 3000, 1);
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // low status byte: short reset, modes, row six, fault, retry, row three, busy
    function [31:0] exp_st(input r3, input rt, input f, input r6, input sb, input be);
        exp_st = {24'h00_0000, 1'b0, be, sb, r6, f, rt, r3, 1'b0};
    endfunction

    initial
    begin
        {fails, checks_done, cyc} = 0;
        {sys_rst_i, avs_read_i, avs_write_i, avs_address_i} = 7'h40;
        avs_writedata_i = 32'h0000_0000;
        {cfg_req, cmp_req} = 16'h0004;
        repeat (20) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        q = $urandom(32'hbe26_0edf);
        // every strap pair, ending on both low
        for (i = 3; i >= 0; i = i - 1)
        begin
            u_mem.pin_reset(i[0], i[1]);
            repeat (8) @(posedge clock_i);
            chk(self_boot_o, !i[0]);
            chk(big_endian_o, !i[1]);
            av(1'b0, 4'h4, 0);
            chk(q & 32'h0000_00ff, exp_st(0, 0, 0, 0, !i[0], !i[1]));
        end
        av(1'b0, 4'h0, 0);
        chk(q, 32'h0000_0010);
        av(1'b0, 4'hc, 0);
        chk(q, 32'h0000_0000);
        // random decode, every column speed, retry last
        for (i = 0; i < 6; i = i + 1)
        begin
            cfg_req <= $urandom;
            cmp_req <= {1'b1, i == 5, $urandom % 2 == 1};
            ctl = 32'h0000_0001 | ((i % 3 + 1) << 4) | ((i % 4) << 8);
            repeat (150) @(posedge clock_i);
            av(1'b1, 4'h0, ctl);
            wait_busy(1);
            wait_busy(0);
            // a decode change while idle must not be captured again
            n = cfg_req;
            cfg_req <= $urandom;
            repeat (150) @(posedge clock_i);
            av(1'b0, 4'h8, 0);
            chk(q, n);
            av(1'b0, 4'h4, 0);
            chk(q & 32'h0000_00ff, exp_st(1, cmp_req[1], cmp_req[0], !cmp_req[1], 1, 1));
        end
        // slow column stalls, then a late retry ends it
        cmp_req <= 3'b000;
        repeat (150) @(posedge clock_i);
        av(1'b1, 4'h0, 32'h0000_0121);
        repeat (1500) @(posedge clock_i);
        chk(access_busy_o, 1);
        cmp_req <= 3'b010;
        wait_busy(0);
        av(1'b0, 4'h4, 0);
        chk(q & 32'h0000_00ef, exp_st(0, 1, 0, 0, 1, 1));
        print_verdict;
    end
endmodule // testbench
